// ==== logic/ddp_pin_ctrl.sv ====
// digital pin control: strap address, snooping, ref clock, csp, gpio mux
`timescale 1ns/1ps

module ddp_pin_ctrl
    import ddp_pkg::*;
#(
    parameter int                REF_DIV_W    = 14,
    parameter logic [ADDR_W-1:0] COMP_REF_REG = 5'h02
) (
    input  wire logic              clock_i,
    input  wire logic              srst_i,
    // strap pins, pad level
    input  wire logic [CHIP_W-1:0] addr_strap_i,
    // decoded register writes seen on the serial bus
    input  wire logic              wr_valid_i,
    input  wire logic [CHIP_W-1:0] wr_chip_i,
    input  wire logic [ADDR_W-1:0] wr_addr_i,
    input  wire logic [REG_W-1:0]  wr_data_i,
    // register read port
    input  wire logic [ADDR_W-1:0] rd_addr_i,
    output logic [REG_W-1:0]       rd_data_o,
    output logic [CHIP_W-1:0]      chip_addr_o,
    // saturation pins, lower one also carries crystal clock
    input  wire logic              upper_saturation_in_i,
    input  wire logic              lower_saturation_in_i,
    input  wire logic              synth_mode_i,
    output ddp_csp_s               csp_o,
    // reference clock request and auxiliary port clock
    input  wire logic              aux_xfer_req_i,
    output logic                   ref_req_o,
    output logic                   aux_clk_en_o,
    // divider outputs to retime
    input  wire logic              divider_out_pos_i,
    input  wire logic              divider_out_neg_i,
    output logic                   pfd_edge_o,
    // gpio port
    input  wire logic [GP_N-1:0]   gp_pin_i,
    output logic [GP_N-1:0]        gp_pin_o,
    output logic [GP_N-1:0]        gp_pin_oe_o,
    input  wire logic [GP_N-1:0]   modulator_bits_out_i,
    input  wire logic              sweep_mode_i,
    input  wire ddp_sweep_s        sweep_flags_i,
    output logic                   sweep_trig_o
);

    // ==========================================================
    // helpers
    function automatic logic rise(input logic now, input logic prev);
        rise = now & ~prev;
    endfunction

    // ==========================================================
    // input synchronisers, two stages, plus a history stage on the lower saturation, divider and top gpio inputs
    logic [CHIP_W-1:0] strap_s1_r;
    logic [CHIP_W-1:0] strap_s2_r;
    logic [1:0]        sat_s1_r;
    logic [1:0]        sat_s2_r;
    logic              dn_s3_r;
    logic [1:0]        div_s1_r;
    logic [1:0]        div_s2_r;
    logic [1:0]        div_s3_r;
    logic [GP_N-1:0]   gp_s1_r;
    logic [GP_N-1:0]   gp_s2_r;
    logic              trig_s3_r;
    // no reset: the strap stages must track the pads during reset
    always_ff @(posedge clock_i) begin
        strap_s1_r <= addr_strap_i;
        strap_s2_r <= strap_s1_r;
        sat_s1_r  <= {upper_saturation_in_i, lower_saturation_in_i};
        sat_s2_r  <= sat_s1_r;
        dn_s3_r   <= sat_s2_r[0];
        div_s1_r  <= {divider_out_pos_i, divider_out_neg_i};
        div_s2_r  <= div_s1_r;
        div_s3_r  <= div_s2_r;
        gp_s1_r   <= gp_pin_i;
        gp_s2_r   <= gp_s1_r;
        trig_s3_r <= gp_s2_r[GP_N-1];
    end

    // ==========================================================
    // chip address strap capture
    logic              cap_pend_r;
    logic [CHIP_W-1:0] chip_addr_r;
    // sampled on the first clock after every reset release
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            cap_pend_r  <= 1'b1;
            chip_addr_r <= STRAP_IDLE;
        end else if (cap_pend_r) begin
            cap_pend_r  <= 1'b0;
            chip_addr_r <= strap_s2_r;
        end
    end

    // ==========================================================
    // register writes: own address or snooped companion
    logic [REG_W-1:0]     gpio_en_r;
    logic [REF_DIV_W-1:0] ref_div_r;
    logic [REG_W-1:0]     aux_cfg_r;
    ddp_gpio_cfg_s        gpio_cfg_r;
    logic [CHIP_W-1:0]    comp_addr_r;
    wire own_wr    = wr_valid_i & ~cap_pend_r & (wr_chip_i == chip_addr_r);
    wire snoop_en  = comp_addr_r != chip_addr_r;
    wire snoop_hit = wr_valid_i & ~cap_pend_r & snoop_en &
                     (wr_chip_i == comp_addr_r) &
                     (wr_addr_i == COMP_REF_REG);
    wire wr_ref    = (own_wr & (wr_addr_i == REG_REF_DIV_A)) | snoop_hit;
    // companion ref divide change mirrored into local divider
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            gpio_en_r   <= REG_RST;
            ref_div_r   <= REF_DIV_W'(REG_RST);
            aux_cfg_r   <= REG_RST;
            gpio_cfg_r  <= REG_RST;
            comp_addr_r <= COMP_ADDR_RST;
        end else begin
            if (own_wr && wr_addr_i == REG_GPIO_EN_A)
                gpio_en_r <= wr_data_i;
            if (wr_ref)
                ref_div_r <= wr_data_i[REF_DIV_W-1:0];
            if (own_wr && wr_addr_i == REG_AUX_A)
                aux_cfg_r <= wr_data_i;
            if (own_wr && wr_addr_i == REG_GPIO_CFG_A)
                gpio_cfg_r <= wr_data_i;
            if (own_wr && wr_addr_i == REG_COMP_A)
                comp_addr_r <= wr_data_i[CHIP_W-1:0];
        end
    end

    // ==========================================================
    // reference clock request and auxiliary clock divider
    logic                 ref_req_r;
    logic [REF_DIV_W-1:0] ref_cnt_r;
    logic                 aux_en_r;
    wire ref_need = aux_xfer_req_i | aux_cfg_r[AUX_KEEP_BIT];
    wire ref_edge = ref_req_r & rise(sat_s2_r[0], dn_s3_r);
    // divide of zero or one passes every edge instead of wrapping
    wire ref_wrap = (ref_div_r <= REF_DIV_W'(1)) |
                    (ref_cnt_r >= ref_div_r - REF_DIV_W'(1));
    always_ff @(posedge clock_i) begin
        if (srst_i)
            ref_req_r <= 1'b0;
        else
            ref_req_r <= ref_need;
    end
    // divider held cleared whenever the clock is not requested
    always_ff @(posedge clock_i) begin
        if (srst_i || !ref_req_r) begin
            ref_cnt_r <= '0;
            aux_en_r  <= 1'b0;
        end else begin
            aux_en_r <= ref_edge & ref_wrap;
            if (ref_edge)
                ref_cnt_r <= ref_wrap ? '0 : ref_cnt_r + REF_DIV_W'(1);
        end
    end

    // ==========================================================
    // cycle-slip prevention
    ddp_csp_s csp_r;
    // lower pin is a clock while the reference is requested
    wire dn_sat = sat_s2_r[0] & ~ref_req_r;
    wire up_sat = sat_s2_r[1];
    always_ff @(posedge clock_i) begin
        if (srst_i || !synth_mode_i) begin
            csp_r <= '0;
        end else begin
            csp_r.div_up   <= up_sat & ~dn_sat;
            csp_r.div_dn   <= dn_sat & ~up_sat;
            csp_r.pfd_hold <= up_sat ^ dn_sat;
        end
    end

    // ==========================================================
    // divider output retiming
    logic pfd_edge_r;

    // only the positive rise and negative fall are low jitter edges
    wire pos_rise = rise(div_s2_r[1], div_s3_r[1]);
    wire neg_fall = rise(~div_s2_r[0], ~div_s3_r[0]);

    always_ff @(posedge clock_i) begin
        if (srst_i)
            pfd_edge_r <= 1'b0;
        else
            pfd_edge_r <= pos_rise | neg_fall;
    end

    // ==========================================================
    // gpio output mux and enables
    logic [GP_N-1:0] gp_out_r;
    logic [GP_N-1:0] gp_oe_r;
    logic            trig_r;
    logic [GP_N-1:0] gp_mux;

    wire master_en = gpio_en_r[GPIO_EN_BIT];

    // unlisted codes fall to zero so a stray code is harmless
    always_comb begin
        gp_mux = '0;
        case (gpio_cfg_r.sel)
            SEL_TEST:  gp_mux = gpio_cfg_r.test;
            SEL_DSM:   gp_mux = modulator_bits_out_i;
            SEL_SWEEP: gp_mux = sweep_mode_i ?
                                {sweep_flags_i, 1'b0} : '0;
            default:   gp_mux = '0;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            gp_out_r <= '0;
            gp_oe_r  <= '0;
            trig_r   <= 1'b0;
        end else begin
            gp_out_r <= gp_mux;
            gp_oe_r  <= master_en ? gpio_cfg_r.dir : '0;
            trig_r   <= sweep_mode_i & master_en &
                        ~gpio_cfg_r.dir[GP_N-1] &
                        rise(gp_s2_r[GP_N-1], trig_s3_r);
        end
    end

    // ==========================================================
    // register read back, unmapped offsets read zero
    logic [REG_W-1:0] rd_data_r;
    logic [REG_W-1:0] rd_mux;

    always_comb begin
        rd_mux = '0;
        case (rd_addr_i)
            REG_GPIO_EN_A:  rd_mux = gpio_en_r;
            REG_REF_DIV_A:  rd_mux = REG_W'(ref_div_r);
            REG_AUX_A:      rd_mux = aux_cfg_r;
            REG_GPIO_CFG_A: rd_mux = gpio_cfg_r;
            REG_COMP_A:     rd_mux = REG_W'(comp_addr_r);
            REG_STATUS_A:   rd_mux = REG_W'({gp_s2_r, ref_req_r,
                                             chip_addr_r});
            default:        rd_mux = '0;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (srst_i)
            rd_data_r <= '0;
        else
            rd_data_r <= rd_mux;
    end

    // ==========================================================
    // outputs
    assign rd_data_o    = rd_data_r;
    assign chip_addr_o  = chip_addr_r;
    assign csp_o        = csp_r;
    assign ref_req_o    = ref_req_r;
    assign aux_clk_en_o = aux_en_r;
    assign pfd_edge_o   = pfd_edge_r;
    assign gp_pin_o     = gp_out_r;
    assign gp_pin_oe_o  = gp_oe_r;
    assign sweep_trig_o = trig_r;

    // ==========================================================
    // checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);
    sequence s_reset_release;
        $past(srst_i) ##0 cap_pend_r;
    endsequence
    a_strap_capture: assert property (
        s_reset_release |=> chip_addr_r == $past(strap_s2_r)
                            ##1 !cap_pend_r)
        else $error("strap address not captured after reset");
    a_strap_hold: assert property (
        !cap_pend_r |=> $stable(chip_addr_r))
        else $error("chip address changed without reset");
    a_snoop_off: assert property (
        (comp_addr_r == chip_addr_r) |-> !snoop_hit)
        else $error("snoop active with own address");
    a_snoop_copy: assert property (
        snoop_hit |=> ref_div_r == $past(wr_data_i[REF_DIV_W-1:0]))
        else $error("snooped divide not mirrored");
    a_ref_request: assert property (
        aux_cfg_r[AUX_KEEP_BIT] |=> ref_req_o)
        else $error("reference request dropped while kept on");
    a_div_off: assert property (
        !ref_req_r |=> ref_cnt_r == '0 && !aux_clk_en_o)
        else $error("aux divider ran without request");
    a_csp_up: assert property (
        synth_mode_i && up_sat && !dn_sat ##1 synth_mode_i
        |-> csp_o.div_up && !csp_o.div_dn)
        else $error("csp did not follow upper saturation");
    a_pfd_retime: assert property (
        (pos_rise || neg_fall) |=> pfd_edge_o)
        else $error("divider edge not retimed");
    a_gpio_hiz: assert property (
        !master_en |=> gp_pin_oe_o == '0)
        else $error("gpio driven with master enable off");
    a_gpio_dir: assert property (
        master_en |=> gp_pin_oe_o == $past(gpio_cfg_r.dir))
        else $error("gpio enable does not follow direction");
    a_mux_test: assert property (
        gpio_cfg_r.sel == SEL_TEST |=> gp_pin_o == $past(gpio_cfg_r.test))
        else $error("test pattern not on pins");
    a_mux_dsm: assert property (
        gpio_cfg_r.sel == SEL_DSM
        |=> gp_pin_o == $past(modulator_bits_out_i))
        else $error("modulator bits not on pins");
    a_sweep_busy: assert property (
        gpio_cfg_r.sel == SEL_SWEEP && sweep_mode_i
        |=> gp_pin_o[1] == $past(sweep_flags_i.busy) && !gp_pin_o[0])
        else $error("sweep busy not on pin one");
    a_reserved_low: assert property (
        gpio_cfg_r.sel inside {4'h1, 4'h3, 4'h4, 4'h5}
        |=> gp_pin_o == '0)
        else $error("reserved select drove pins");
    a_trigger: assert property (
        sweep_trig_o |->
        !$past(gpio_cfg_r.dir[GP_N-1]) && $past(sweep_mode_i))
        else $error("trigger with pin four not an input");

endmodule

// ==== logic/ddp_pkg.sv ====
// shared constants and types for the divider digital pin control block
package ddp_pkg;

    // ==========================================================
    // widths
    localparam int REG_W  = 24;
    localparam int ADDR_W = 5;
    localparam int CHIP_W = 3;
    localparam int GP_N   = 5;

    // ==========================================================
    // register offsets
    localparam logic [ADDR_W-1:0] REG_GPIO_EN_A  = 5'h01;
    localparam logic [ADDR_W-1:0] REG_REF_DIV_A  = 5'h02;
    localparam logic [ADDR_W-1:0] REG_AUX_A      = 5'h04;
    localparam logic [ADDR_W-1:0] REG_GPIO_CFG_A = 5'h08;
    localparam logic [ADDR_W-1:0] REG_COMP_A     = 5'h09;
    localparam logic [ADDR_W-1:0] REG_STATUS_A   = 5'h1f;

    // ==========================================================
    // field positions and reset values
    localparam int GPIO_EN_BIT  = 4;
    localparam int AUX_KEEP_BIT = 15;
    localparam logic [REG_W-1:0]  REG_RST       = 24'h00_0000;
    localparam logic [CHIP_W-1:0] STRAP_IDLE    = 3'h7;
    localparam logic [CHIP_W-1:0] COMP_ADDR_RST = 3'h0;

    // ==========================================================
    // output select codes
    localparam logic [3:0] SEL_TEST  = 4'h0;
    localparam logic [3:0] SEL_DSM   = 4'h2;
    localparam logic [3:0] SEL_SWEEP = 4'h8;

    // ==========================================================
    // pin configuration register layout
    typedef struct packed {
        logic [9:0]      rsvd;
        logic [GP_N-1:0] dir;   // 1 = pin drives out
        logic [GP_N-1:0] test;  // test pattern, bit 4 on pin 4
        logic [3:0]      sel;   // internal signal select
    } ddp_gpio_cfg_s;

    // sweep status flags from the sweeper
    typedef struct packed {
        logic ready;
        logic start;
        logic stop;
        logic busy;
    } ddp_sweep_s;

    // cycle-slip correction requests
    typedef struct packed {
        logic div_up;
        logic div_dn;
        logic pfd_hold;
    } ddp_csp_s;

endpackage

// ==== sim/ddp_companion_model.sv ====
// behavioural companion chip: saturation levels and crystal clock
`timescale 1ns/1ps
module ddp_companion_model (
    input  wire logic ref_req_i,
    input  wire logic run_i,
    input  wire logic up_i,
    input  wire logic dn_i,
    output logic      upper_sat_o,
    output logic      lower_sat_o,
    output int        edges_o
);
    logic xtal = 1'b0;

    // ==========================================================
    // crystal clock, own timebase so its phase drifts past clock_i
    initial edges_o = 0;
    always begin
        #170;
        if (ref_req_i && run_i) begin
            xtal = ~xtal;
            if (xtal) edges_o++;
        end else begin
            xtal = 1'b0; // rests low outside a request
        end
    end

    // ==========================================================
    // pin sharing: crystal replaces the lower flag while requested
    assign lower_sat_o = ref_req_i ? xtal : dn_i;
    assign upper_sat_o = up_i;
endmodule

// ==== sim/ddp_pin_ctrl_tb.sv ====
// self-checking bench for the digital pin control block
`timescale 1ns/1ps
module ddp_pin_ctrl_tb
    import ddp_pkg::*;
;
    // ==========================================================
    // stimulus and observed signals
    logic              clock    = 1'b0;
    logic              srst     = 1'b1;
    logic [2:0]        gnd      = 3'h0;
    tri1  [2:0]        strap;
    logic              wr_valid = 1'b0;
    logic [CHIP_W-1:0] wr_chip  = '0;
    logic [ADDR_W-1:0] wr_addr  = '0;
    logic [ADDR_W-1:0] rd_addr  = '0;
    logic [REG_W-1:0]  wr_data  = '0;
    logic [REG_W-1:0]  rd_data;
    logic [CHIP_W-1:0] chip_addr;
    logic              up = 1'b0, dn = 1'b0, run = 1'b0, synth = 1'b0;
    logic              aux_req = 1'b0, pos = 1'b0, neg = 1'b0;
    logic              swp = 1'b0;
    logic              up_sat, dn_sat, ref_req, aux_en, pfd_edge, trig;
    ddp_csp_s          cycle_slip_prevention;
    ddp_sweep_s        flags    = '0;
    logic [GP_N-1:0]   gp_drv   = '0;
    logic [GP_N-1:0]   mod_bits = '0;
    logic [GP_N-1:0]   gp_o, gp_oe, gp_w;
    logic [3:0]        rsv[4]   = '{4'h1, 4'h3, 4'h4, 4'h5};
    int                pulses[3];
    int                fail_count = 0;
    int                tests_run  = 0;
    int                xe, xe0;

    // straps: grounded pins read zero, open pins ride the pull-up
    for (genvar k = 0; k < CHIP_W; k++) begin : g_strap
        assign strap[k] = gnd[k] ? 1'b0 : 1'bz;
    end
    // pad level: design drive wins wherever it is enabled
    assign gp_w = (gp_oe & gp_o) | (~gp_oe & gp_drv);
    always #20 clock = ~clock;

    ddp_pin_ctrl ddp_pin_ctrl_i (
        .clock_i(clock), .srst_i(srst), .addr_strap_i(strap),
        .wr_valid_i(wr_valid), .wr_chip_i(wr_chip),
        .wr_addr_i(wr_addr), .wr_data_i(wr_data),
        .rd_addr_i(rd_addr), .rd_data_o(rd_data),
        .chip_addr_o(chip_addr), .upper_saturation_in_i(up_sat),
        .lower_saturation_in_i(dn_sat), .synth_mode_i(synth),
        .csp_o(cycle_slip_prevention), .aux_xfer_req_i(aux_req), .ref_req_o(ref_req),
        .aux_clk_en_o(aux_en), .divider_out_pos_i(pos),
        .divider_out_neg_i(neg), .pfd_edge_o(pfd_edge),
        .gp_pin_i(gp_w), .gp_pin_o(gp_o), .gp_pin_oe_o(gp_oe),
        .modulator_bits_out_i(mod_bits), .sweep_mode_i(swp),
        .sweep_flags_i(flags), .sweep_trig_o(trig)
    );

    ddp_companion_model ddp_companion_model_i (
        .ref_req_i(ref_req), .run_i(run), .up_i(up), .dn_i(dn),
        .upper_sat_o(up_sat), .lower_sat_o(dn_sat), .edges_o(xe)
    );

    // pulse counters for the one-cycle outputs
    always @(posedge clock) begin
        if (pfd_edge === 1'b1) pulses[0]++;
        if (aux_en === 1'b1) pulses[1]++;
        if (trig === 1'b1) pulses[2]++;
    end

    // ==========================================================
    // access and compare tasks
    task automatic wait_n(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic chk(input string n, input logic [23:0] e, g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic chk_pin(input string n, input logic [4:0] e, g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic chk_n(input string n, input int e, g);
        tests_run++;
        if (g != e) begin
            fail_count++;
            $display("BAD %s exp %0d got %0d", n, e, g);
        end
    endtask
    // leading wait keeps valid from being assigned twice in a step
    task automatic wr(input logic [2:0] c, input logic [4:0] a,
                      input logic [23:0] d);
        @(negedge clock);
        wr_valid = 1'b1;
        wr_chip  = c;
        wr_addr  = a;
        wr_data  = d;
        @(negedge clock);
        wr_valid = 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, input logic [23:0] e,
                      input string n);
        @(negedge clock);
        rd_addr = a;
        @(negedge clock);
        chk(n, e, rd_data);
    endtask
    task automatic gcfg(input logic [4:0] d, t, input logic [3:0] s);
        wr(3'h5, REG_GPIO_CFG_A, {10'h0, d, t, s});
        wait_n(3);
    endtask
    task automatic csp_case(input logic s, u, d, input logic [2:0] e);
        synth = s;
        up    = u;
        dn    = d;
        wait_n(6);
        chk("csp", 24'(e), 24'(cycle_slip_prevention));
    endtask
    task automatic edge_case(input logic p, n, input int e);
        pulses[0] = 0;
        pos = p;
        neg = n;
        wait_n(7);
        chk_n("pfd_edge", e, pulses[0]);
    endtask
    task automatic complete_run();
        if (fail_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ==========================================================
    // watchdog: the whole sequence needs well under 40 us
    initial begin
        #100000;
        fail_count++;
        complete_run();
    end

    // ==========================================================
    // test sequence
    initial begin
        wait_n(2);
        chk("chip_rst", 24'h7, 24'(chip_addr));
        chk_pin("oe_rst", 5'h00, gp_oe);
        srst = 1'b0;
        wait_n(4);
        chk("chip_open", 24'h7, 24'(chip_addr));
        gnd  = 3'h2;
        srst = 1'b1;
        wait_n(2);
        srst = 1'b0;
        wait_n(4);
        chk("chip_strap", 24'h5, 24'(chip_addr));
        rd(REG_STATUS_A, 24'h000005, "status");
        rd(5'h03, 24'h0, "unmapped");
        chk_pin("oe_idle", 5'h00, gp_oe);
        wr(3'h5, REG_GPIO_EN_A, 24'h10);
        rd(REG_GPIO_EN_A, 24'h10, "gpio_en");
        gcfg(5'h1f, 5'h15, SEL_TEST);
        chk_pin("test", 5'h15, gp_o);
        chk_pin("dir_all", 5'h1f, gp_oe);
        rd(REG_GPIO_CFG_A, 24'h003f50, "cfg");
        gcfg(5'h0a, 5'h15, SEL_TEST);
        chk_pin("dir_part", 5'h0a, gp_oe);
        mod_bits = 5'h19;
        gcfg(5'h1f, 5'h00, SEL_DSM);
        chk_pin("dsm", 5'h19, gp_o);
        swp   = 1'b1;
        flags = 4'b1011;
        gcfg(5'h1f, 5'h00, SEL_SWEEP);
        chk_pin("sweep", 5'h16, gp_o);
        flags = 4'b1010;
        wait_n(3);
        chk_pin("busy_low", 5'h14, gp_o);
        swp = 1'b0;
        wait_n(3);
        chk_pin("no_sweep", 5'h00, gp_o);
        foreach (rsv[i]) begin
            gcfg(5'h1f, 5'h1f, rsv[i]);
            chk_pin("reserved", 5'h00, gp_o);
        end
        wr(3'h5, REG_GPIO_EN_A, 24'h0);
        wait_n(3);
        chk_pin("oe_off", 5'h00, gp_oe);
        // external trigger on the top pin, then outside sweep mode
        wr(3'h5, REG_GPIO_EN_A, 24'h10);
        swp = 1'b1;
        gcfg(5'h0f, 5'h00, SEL_TEST);
        pulses[2] = 0;
        gp_drv[4] = 1'b1;
        wait_n(8);
        chk_n("trig", 1, pulses[2]);
        gp_drv[4] = 1'b0;
        swp = 1'b0;
        wait_n(4);
        gp_drv[4] = 1'b1;
        wait_n(8);
        chk_n("trig_off", 1, pulses[2]);
        gp_drv[4] = 1'b0;
        // crystal clock request and divided port clock
        wr(3'h5, REG_REF_DIV_A, 24'h3);
        aux_req = 1'b1;
        wait_n(2);
        chk("ref_req", 24'h1, 24'(ref_req));
        pulses[1] = 0;
        xe0 = xe;
        run = 1'b1;
        wait_n(150);
        run = 1'b0;
        wait_n(10);
        chk_n("aux_clk", (xe - xe0) / 3, pulses[1]);
        // divide of one: every crystal edge gives a port clock
        wr(3'h5, REG_REF_DIV_A, 24'h1);
        pulses[1] = 0;
        xe0 = xe;
        run = 1'b1;
        wait_n(60);
        run = 1'b0;
        wait_n(10);
        chk_n("aux_clk_r1", xe - xe0, pulses[1]);
        aux_req = 1'b0;
        wait_n(3);
        chk("ref_idle", 24'h0, 24'(ref_req));
        wr(3'h5, REG_AUX_A, 24'h008000);
        wait_n(3);
        chk("ref_keep", 24'h1, 24'(ref_req));
        wr(3'h5, REG_AUX_A, 24'h0);
        wait_n(3);
        csp_case(1'b1, 1'b1, 1'b0, 3'b101);
        csp_case(1'b1, 1'b0, 1'b1, 3'b011);
        csp_case(1'b1, 1'b1, 1'b1, 3'b000);
        csp_case(1'b0, 1'b1, 1'b0, 3'b000);
        edge_case(1'b1, 1'b0, 1);
        edge_case(1'b0, 1'b0, 0);
        edge_case(1'b0, 1'b1, 0);
        edge_case(1'b0, 1'b0, 1);
        // companion writes mirrored, then snooping switched off
        wr(3'h5, REG_COMP_A, 24'h2);
        rd(REG_COMP_A, 24'h2, "comp");
        wr(3'h2, 5'h02, 24'h7);
        rd(REG_REF_DIV_A, 24'h7, "snoop");
        wr(3'h5, REG_COMP_A, 24'h5);
        wr(3'h2, 5'h02, 24'h9);
        rd(REG_REF_DIV_A, 24'h7, "snoop_off");
        complete_run();
    end
endmodule
